// ===== hdl/coid_decoder.sv
// Cyclic output image decoder with entry data FIFO and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Entry data FIFO
module coid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT = CW'(1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // Occupancy after this cycle's push and pop
  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + ONE_CNT;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - ONE_CNT;
    end
  end

  // Flags are registered so both handshakes come straight from flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != FULL_CNT);
      out_valid <= (cnt_next != '0);
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Storage has no reset; it is never read while empty
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule // coid_fifo

////////////////////////////////////////////////////////////////////////////////
// Decoder top
module coid_decoder #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Image byte stream from the fieldbus side
  input wire logic img_valid,
  output logic img_ready,
  input wire coid_pkg::coid_img_byte_type img_byte,
  // Entry data stream to the reader core
  output logic ent_valid,
  input wire logic ent_ready,
  output logic [7:0] ent_data,
  // Decoded image
  output coid_pkg::coid_ctrl_type ctrl_out,
  output logic [1:0] sw_out,
  output coid_pkg::coid_cfg_type cfg_out,
  output logic image_done,
  // AXI4-Lite slave
  input wire logic [coid_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [coid_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import coid_pkg::*;

  // Software registers
  logic short_reg;
  logic [1:0] ext_event_reg;
  logic [LEN_W-1:0] len_reg;
  // Decode state
  logic [LEN_W-1:0] idx_reg;
  logic [7:0] sh_ctrl0_reg, sh_ctrl1_reg, sh_num_reg, sh_rem_reg, sh_size_reg, sh_flags_reg;
  logic [15:0] sh_elen_reg;
  logic [7:0] frag_num_reg, frag_rem_reg, frag_size_reg, flags_reg;
  logic [15:0] entry_len_reg;
  logic toggle_seen_reg;
  logic accept_reg;
  logic commit_reg;
  logic [31:0] img_count_reg;
  logic [31:0] entry_count_reg;
  // Bus state
  logic aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // Combinational
  logic [LEN_W-1:0] max_len, eff_len, cur_idx;
  logic [LEN_W-1:0] ofs_num, ofs_rem, ofs_size, ofs_flags, ofs_lo, ofs_hi, ofs_data;
  logic take, in_image, is_last, is_data, fifo_in_ready, fifo_push;
  logic do_write;
  logic [31:0] rd_word;
  logic rd_err;

  //////////////////////////////////////////////////////////////////////////////
  // Layout selection and length clamp
  // Out-of-range lengths are clamped so a bad setting cannot wedge framing
  always_comb begin
    max_len = short_reg ? SHORT_MAX_LEN : FULL_MAX_LEN;
    eff_len = len_reg;
    if (len_reg < MIN_LEN) begin
      eff_len = MIN_LEN;
    end else if (len_reg > max_len) begin
      eff_len = max_len;
    end
  end

  // Field offsets per layout
  always_comb begin
    ofs_num = short_reg ? SHORT_OFS_FRAG_NUM : FULL_OFS_FRAG_NUM;
    ofs_rem = short_reg ? SHORT_OFS_FRAG_REM : FULL_OFS_FRAG_REM;
    ofs_size = short_reg ? SHORT_OFS_FRAG_SIZE : FULL_OFS_FRAG_SIZE;
    ofs_flags = short_reg ? SHORT_OFS_FLAGS : FULL_OFS_FLAGS;
    ofs_lo = short_reg ? SHORT_OFS_LEN_LO : FULL_OFS_LEN_LO;
    ofs_hi = short_reg ? SHORT_OFS_LEN_HI : FULL_OFS_LEN_HI;
    ofs_data = short_reg ? SHORT_OFS_DATA : FULL_OFS_DATA;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte framing
  // The first flag resynchronises; without it the count alone frames images
  assign take = img_valid & img_ready;
  assign cur_idx = img_byte.first ? OFS_CTRL0 : idx_reg;
  assign in_image = cur_idx < eff_len;
  assign is_last = cur_idx == (eff_len - MIN_LEN);
  assign is_data = in_image && (cur_idx >= ofs_data);
  assign fifo_push = take & is_data & accept_reg;
  // The whole stream stalls on a full FIFO, costing control bytes some latency
  assign img_ready = fifo_in_ready;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_reg <= OFS_CTRL0;
    end else if (take) begin
      idx_reg <= (is_last || !in_image) ? OFS_CTRL0 : cur_idx + MIN_LEN;
    end
  end

  // Shadow fields; byte 0 clears the rest so absent bytes decode as zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_ctrl0_reg <= '0;
      sh_ctrl1_reg <= '0;
      sh_num_reg <= '0;
      sh_rem_reg <= '0;
      sh_size_reg <= '0;
      sh_flags_reg <= '0;
      sh_elen_reg <= '0;
    end else if (take && in_image) begin
      if (cur_idx == OFS_CTRL0) begin
        sh_ctrl0_reg <= img_byte.data;
        sh_ctrl1_reg <= '0;
        sh_num_reg <= '0;
        sh_rem_reg <= '0;
        sh_size_reg <= '0;
        sh_flags_reg <= '0;
        sh_elen_reg <= '0;
      end
      if (!short_reg && cur_idx == FULL_OFS_CTRL1) begin
        sh_ctrl1_reg <= img_byte.data;
      end
      if (cur_idx == ofs_num) begin
        sh_num_reg <= img_byte.data;
      end
      if (cur_idx == ofs_rem) begin
        sh_rem_reg <= img_byte.data;
      end
      if (cur_idx == ofs_size) begin
        sh_size_reg <= img_byte.data;
      end
      if (cur_idx == ofs_flags) begin
        sh_flags_reg <= img_byte.data;
      end
      if (cur_idx == ofs_lo) begin
        sh_elen_reg[7:0] <= img_byte.data;
      end
      if (cur_idx == ofs_hi) begin
        sh_elen_reg[15:8] <= img_byte.data;
      end
    end
  end

  // Entry acceptance: data of this image pass only if the toggle moved
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      toggle_seen_reg <= 1'b0;
      accept_reg <= 1'b0;
    end else if (take && in_image) begin
      if (cur_idx == OFS_CTRL0) begin
        accept_reg <= 1'b0;
      end
      if (cur_idx == ofs_flags) begin
        accept_reg <= img_byte.data[FLAG_TOGGLE] != toggle_seen_reg;
        toggle_seen_reg <= img_byte.data[FLAG_TOGGLE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Commit one cycle after the last byte, so that byte is already in shadow
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      commit_reg <= 1'b0;
      image_done <= 1'b0;
      ctrl_out <= '0;
      sw_out <= '0;
      frag_num_reg <= '0;
      frag_rem_reg <= '0;
      frag_size_reg <= '0;
      flags_reg <= '0;
      entry_len_reg <= '0;
      img_count_reg <= '0;
    end else begin
      commit_reg <= take & in_image & is_last;
      image_done <= commit_reg;
      if (commit_reg) begin
        ctrl_out.act_sig <= sh_ctrl0_reg[B0_ACT];
        ctrl_out.data_ack <= sh_ctrl0_reg[B0_DATA_ACK];
        ctrl_out.data_rst <= sh_ctrl0_reg[B0_DATA_RST];
        ctrl_out.err_ack <= sh_ctrl0_reg[B0_ERR_ACK];
        ctrl_out.standby <= sh_ctrl0_reg[B0_STANDBY];
        ctrl_out.out1_act <= sh_ctrl1_reg[B1_OUT1_ACT];
        ctrl_out.cnt1_rst <= sh_ctrl1_reg[B1_CNT1_RST];
        ctrl_out.out2_act <= sh_ctrl1_reg[B1_OUT2_ACT];
        ctrl_out.cnt2_rst <= sh_ctrl1_reg[B1_CNT2_RST];
        sw_out[0] <= sh_ctrl1_reg[B1_OUT1_ACT] & ext_event_reg[0];
        sw_out[1] <= sh_ctrl1_reg[B1_OUT2_ACT] & ext_event_reg[1];
        frag_num_reg <= sh_num_reg;
        frag_rem_reg <= sh_rem_reg;
        frag_size_reg <= sh_size_reg;
        flags_reg <= sh_flags_reg;
        entry_len_reg <= sh_elen_reg;
        img_count_reg <= img_count_reg + 32'h0000_0001;
      end else begin
        // Function setting may change between images
        sw_out[0] <= ctrl_out.out1_act & ext_event_reg[0];
        sw_out[1] <= ctrl_out.out2_act & ext_event_reg[1];
      end
    end
  end

  // Count of accepted entry bytes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      entry_count_reg <= '0;
    end else if (fifo_push) begin
      entry_count_reg <= entry_count_reg + 32'h0000_0001;
    end
  end

  coid_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(img_byte.data),
    .out_valid(ent_valid),
    .out_ready(ent_ready),
    .out_data(ent_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order, then response
  assign do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg > ADDR_COUNT || awaddr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers; a length change mid-image reframes the current image
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      short_reg <= CTRL_RESET[0];
      ext_event_reg <= CTRL_RESET[2:1];
      len_reg[7:0] <= LEN_RESET[7:0];
      cfg_out <= CONFIG_RESET[2:0];
    end else if (do_write && wstrb_reg[0]) begin
      if (awaddr_reg == ADDR_CTRL) begin
        short_reg <= wdata_reg[0];
        ext_event_reg <= wdata_reg[2:1];
      end
      if (awaddr_reg == ADDR_LEN) begin
        len_reg[7:0] <= wdata_reg[7:0];
      end
      if (awaddr_reg == ADDR_CONFIG) begin
        cfg_out <= wdata_reg[2:0];
      end
    end
  end

  // High length bit sits in byte lane 1
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      len_reg[LEN_W-1] <= LEN_RESET[LEN_W-1];
    end else if (do_write && wstrb_reg[1] && awaddr_reg == ADDR_LEN) begin
      len_reg[LEN_W-1] <= wdata_reg[LEN_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_word = {29'h0, ext_event_reg, short_reg};
      ADDR_LEN: rd_word = {23'h0, len_reg};
      ADDR_CONFIG: rd_word = {29'h0, cfg_out};
      ADDR_STATUS: rd_word = {19'h0, sw_out, fifo_in_ready, ent_valid, ctrl_out};
      ADDR_FRAG: rd_word = {8'h0, frag_size_reg, frag_rem_reg, frag_num_reg};
      ADDR_ENTRY: rd_word = {6'h0, flags_reg[FLAG_TOGGLE], flags_reg[FLAG_NEW_DATA], 8'h0, entry_len_reg};
      ADDR_COUNT: rd_word = {img_count_reg[15:0], entry_count_reg[15:0]};
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // coid_decoder

`default_nettype wire

// ===== hdl/coid_pkg.sv
// Package: constants, field layout and carrier types of the output image decoder
package coid_pkg;
  // Image geometry
  localparam int LEN_W = 9;
  localparam logic [LEN_W-1:0] FULL_MAX_LEN = 9'h107;
  localparam logic [LEN_W-1:0] SHORT_MAX_LEN = 9'h106;
  localparam logic [LEN_W-1:0] MIN_LEN = 9'h001;
  // Byte offsets, both variants
  localparam logic [LEN_W-1:0] OFS_CTRL0 = 9'h000;
  localparam logic [LEN_W-1:0] FULL_OFS_CTRL1 = 9'h001;
  localparam logic [LEN_W-1:0] FULL_OFS_FRAG_NUM = 9'h002;
  localparam logic [LEN_W-1:0] FULL_OFS_FRAG_REM = 9'h003;
  localparam logic [LEN_W-1:0] FULL_OFS_FRAG_SIZE = 9'h004;
  localparam logic [LEN_W-1:0] FULL_OFS_FLAGS = 9'h005;
  localparam logic [LEN_W-1:0] FULL_OFS_LEN_LO = 9'h006;
  localparam logic [LEN_W-1:0] FULL_OFS_LEN_HI = 9'h007;
  localparam logic [LEN_W-1:0] FULL_OFS_DATA = 9'h008;
  localparam logic [LEN_W-1:0] SHORT_OFS_FRAG_NUM = 9'h001;
  localparam logic [LEN_W-1:0] SHORT_OFS_FRAG_REM = 9'h002;
  localparam logic [LEN_W-1:0] SHORT_OFS_FRAG_SIZE = 9'h003;
  localparam logic [LEN_W-1:0] SHORT_OFS_FLAGS = 9'h004;
  localparam logic [LEN_W-1:0] SHORT_OFS_LEN_LO = 9'h005;
  localparam logic [LEN_W-1:0] SHORT_OFS_LEN_HI = 9'h006;
  localparam logic [LEN_W-1:0] SHORT_OFS_DATA = 9'h007;
  // Bit positions
  localparam int B0_ACT = 0;
  localparam int B0_DATA_ACK = 1;
  localparam int B0_DATA_RST = 2;
  localparam int B0_ERR_ACK = 3;
  localparam int B0_STANDBY = 4;
  localparam int B1_OUT1_ACT = 0;
  localparam int B1_CNT1_RST = 1;
  localparam int B1_OUT2_ACT = 2;
  localparam int B1_CNT2_RST = 3;
  localparam int FLAG_NEW_DATA = 3;
  localparam int FLAG_TOGGLE = 4;
  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LEN = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_FRAG = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ENTRY = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LEN_RESET = 32'h0000_0107;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Image byte as it arrives from the fieldbus side
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } coid_img_byte_type;
  // Decoded control bits of bytes 0 and 1
  typedef struct packed {
    logic standby;
    logic err_ack;
    logic data_rst;
    logic data_ack;
    logic act_sig;
    logic cnt2_rst;
    logic out2_act;
    logic cnt1_rst;
    logic out1_act;
  } coid_ctrl_type;
  // Connection configuration image, bit 0 of each byte
  typedef struct packed {
    logic entry_frag;
    logic result_frag;
    logic ack_mode;
  } coid_cfg_type;
endpackage

// ===== verification/coid_ctrl_model.sv
// Controller-side model sending cyclic output images byte by byte
`timescale 1ns/1ps
`default_nettype none
module coid_ctrl_model
  import coid_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Image stream
  input wire logic img_ready,
  output logic img_valid,
  output coid_pkg::coid_img_byte_type img_byte
);
  // Image buffer, filled by the bench before each send
  logic [7:0] img [0:271];

  // Idle line at start
  initial begin
    img_valid = 1'b0;
    img_byte = '0;
  end

  // One whole image per call, each byte held until taken
  task send_image(input int len);
    int i;
    @(posedge sys_clk);
    for (i = 0; i < len; i++) begin
      img_valid <= 1'b1;
      img_byte <= '{first: (i == 0), data: img[i]};
      do @(posedge sys_clk); while (img_ready !== 1'b1);
    end
    // Released line shows the inverse, so a stale byte never looks fresh
    img_valid <= 1'b0;
    img_byte <= '{first: 1'b0, data: ~img[len-1]};
  endtask
endmodule // coid_ctrl_model
`default_nettype wire

// ===== verification/coid_decoder_monitor.sv
// Port checker for the output image decoder, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module coid_decoder_monitor
  import coid_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Streams
  input wire logic img_ready,
  input wire logic ent_valid,
  input wire logic ent_ready,
  input wire logic [7:0] ent_data,
  // Decoded image
  input wire coid_pkg::coid_ctrl_type ctrl_out,
  input wire logic [1:0] sw_out,
  input wire coid_pkg::coid_cfg_type cfg_out,
  input wire logic image_done,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Image stream and decoded outputs
  a_img_stall: assert property (!img_ready |-> ent_valid)
    else $error("image stalled with empty entry buffer");
  a_ent_hold: assert property (ent_valid && !ent_ready |=> ent_valid && $stable(ent_data))
    else $error("entry byte dropped or changed while waiting");
  a_ctrl_commit: assert property ($changed(ctrl_out) |-> image_done)
    else $error("control outputs moved outside an image commit");
  a_sw1_gate: assert property (sw_out[0] |-> ctrl_out.out1_act || $past(ctrl_out.out1_act))
    else $error("output 1 driven without its activation bit");
  a_sw2_gate: assert property (sw_out[1] |-> ctrl_out.out2_act || $past(ctrl_out.out2_act))
    else $error("output 2 driven without its activation bit");
  a_cfg_default: assert property ($rose(arst_n) |-> cfg_out == 3'h0)
    else $error("configuration bits not zero after reset");

  ////////////////////////////////////////////////////////////////////////////
  // Register bus answers
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // coid_decoder_monitor

bind coid_decoder coid_decoder_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
  .sys_clk, .arst_n, .img_ready, .ent_valid, .ent_ready, .ent_data,
  .ctrl_out, .sw_out, .cfg_out, .image_done,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the output image decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import coid_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic img_valid, img_ready, ent_valid, image_done, ent_ready;
  coid_img_byte_type img_byte;
  logic [7:0] ent_data;
  coid_ctrl_type ctrl_out;
  logic [1:0] sw_out;
  coid_cfg_type cfg_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [31:0] rd_val;
  int err_total = 0;
  int check_count = 0;
  int t;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  coid_decoder #(.FIFO_DEPTH(8)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .img_valid(img_valid), .img_ready(img_ready),
    .img_byte(img_byte), .ent_valid(ent_valid), .ent_ready(ent_ready), .ent_data(ent_data),
    .ctrl_out(ctrl_out), .sw_out(sw_out), .cfg_out(cfg_out), .image_done(image_done),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  coid_ctrl_model ctl (.sys_clk(sys_clk), .img_ready(img_ready), .img_valid(img_valid), .img_byte(img_byte));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write with address and data offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rd_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd_val, rd_resp);
    check(rd_val, exp);
  endtask

  // Commit pulse is one cycle, so it is looked for at every falling edge
  task wait_done;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while (image_done !== 1'b1 && t < 50);
    check(32'(image_done), 32'h0000_0001);
  endtask

  // Drain entry bytes, expected pattern A0, A1, ...
  task drain(input int cnt);
    int got;
    got = 0;
    t = 0;
    @(posedge sys_clk);
    ent_ready <= 1'b1;
    while (got < cnt && t < 500) begin
      @(negedge sys_clk);
      t++;
      if (ent_valid === 1'b1) begin
        check(32'(ent_data), 32'(8'hA0 + got));
        got++;
      end
      @(posedge sys_clk);
    end
    ent_ready <= 1'b0;
    check(got, cnt);
  endtask

  // Header plus nd data bytes; short layout shifts everything after byte 0 down one
  task build(input int sh, input int nd, input logic [7:0] fl);
    int b;
    b = 2 - sh;
    ctl.img[0] = 8'h00;
    ctl.img[b] = 8'h12;
    ctl.img[b+1] = 8'h34;
    ctl.img[b+2] = 8'h56;
    ctl.img[b+3] = fl;
    ctl.img[b+4] = nd[7:0];
    ctl.img[b+5] = 8'h01;
    for (int i = 0; i < nd; i++) ctl.img[b+6+i] = 8'hA0 + 8'(i);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {ent_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_chk(ADDR_CTRL, CTRL_RESET);
    rd_chk(ADDR_LEN, LEN_RESET);
    rd_chk(ADDR_CONFIG, CONFIG_RESET);
    check(32'(cfg_out), 32'h0000_0000);
    axi_wr(ADDR_CONFIG, 32'h0000_0007);
    repeat (2) @(posedge sys_clk);
    check(32'(cfg_out), 32'h0000_0007);
    axi_wr(ADDR_LEN, 32'h0000_01FF);
    rd_chk(ADDR_LEN, 32'h0000_01FF);
    axi_wr(ADDR_LEN, 32'h0000_0000);
    rd_chk(ADDR_LEN, 32'h0000_0000);
    axi_rd(8'h40, rd_val, rd_resp);
    check(32'(rd_resp), 32'(RESP_SLVERR));
    axi_wr(8'h40, 32'h0000_0000);
    check(32'(rd_resp), 32'(RESP_SLVERR));
    $display("test registers done");
    // One-byte image: byte 1 present in the buffer but never sent
    ctl.img[0] = 8'h1F;
    ctl.img[1] = 8'h0F;
    ctl.send_image(1);
    wait_done();
    check(32'(ctrl_out), 32'h0000_01F0);
    // Two-byte image with only output 1 on an external event
    axi_wr(ADDR_CTRL, 32'h0000_0002);
    axi_wr(ADDR_LEN, 32'h0000_0002);
    ctl.img[0] = 8'h00;
    ctl.send_image(2);
    wait_done();
    check(32'(ctrl_out), 32'h0000_000F);
    repeat (2) @(posedge sys_clk);
    check(32'(sw_out), 32'h0000_0001);
    $display("test control bytes done");
    // Full layout, 11 entry bytes against a stalled reader: buffer fills
    axi_wr(ADDR_CTRL, 32'h0000_0000);
    axi_wr(ADDR_LEN, 32'h0000_0013);
    build(0, 11, 8'h18);
    fork
      ctl.send_image(19);
    join_none
    t = 0;
    while (img_ready !== 1'b0 && t < 300) begin
      @(negedge sys_clk);
      t++;
    end
    check(32'(img_ready), 32'h0000_0000);
    drain(11);
    wait fork;
    rd_chk(ADDR_FRAG, 32'h0056_3412);
    rd_chk(ADDR_ENTRY, 32'h0300_010B);
    rd_chk(ADDR_COUNT, 32'h0003_000B);
    // Same toggle again: no new entry accepted
    axi_wr(ADDR_LEN, 32'h0000_000B);
    build(0, 3, 8'h18);
    ctl.send_image(11);
    wait_done();
    check(32'(ent_valid), 32'h0000_0000);
    rd_chk(ADDR_COUNT, 32'h0004_000B);
    $display("test full layout done");
    // Short layout
    axi_wr(ADDR_CTRL, 32'h0000_0001);
    axi_wr(ADDR_LEN, 32'h0000_01FF);
    rd_chk(ADDR_LEN, 32'h0000_01FF);
    axi_wr(ADDR_LEN, 32'h0000_000A);
    build(1, 3, 8'h08);
    ctl.send_image(10);
    drain(3);
    rd_chk(ADDR_FRAG, 32'h0056_3412);
    rd_chk(ADDR_ENTRY, 32'h0100_0103);
    rd_chk(ADDR_COUNT, 32'h0005_000E);
    $display("test short layout done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
